// >>> logic/lsc_ctrl.sv
`default_nettype none
module lsc_ctrl (
    input wire logic sys_clk, // 100 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic int_3v3_pg, // internal 3v3 regulator good
    input wire logic int_5v_pg, // internal 5v regulator good
    input wire logic master_enable_pin, // master enable pin
    input wire logic sleep_s4_n, // s4 sleep input
    input wire logic sleep_s3_n, // s3 sleep input
    input wire logic sleep_s0_n, // s0 sleep input
    input wire logic thermal_trip_n, // thermal trip input
    input wire logic shared_ldo_switch_enable, // shared enable pin
    input wire logic ddr_supply_power_good, // ddr buck power good
    input wire logic strap_ldo1_always_on, // variant: first ldo always-on
    input wire logic strap_lpddr, // memory: low-power ddr
    input wire logic strap_ldo_in_seq, // ldo2/3/switch a in sequence
    input wire logic strap_vtt_off, // termination ldo fused off
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // register write data
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    output logic [7:0] reg_rdata, // register read data
    output logic reg_rvalid, // read data valid pulse
    output logic dev_ready, // out of reset, registers live
    output lsc_pkg::lsc_state_t power_state, // decoded power state
    output logic resume_reset_n, // resume reset output
    output logic platform_power_ok, // platform power ok output
    output logic aon_bucks_en, // north complex, 1v8, 1v24 bucks
    output logic termination_ldo_en, // termination ldo enable
    output logic aux_ldo_first_en, // first aux ldo enable
    output logic aux_ldo_second_en, // second aux ldo enable
    output logic aux_ldo_third_en, // third aux ldo enable
    output logic load_switch_a_en, // load switch a enable
    output logic combined_switch_b_en, // combined switch b enable
    output logic [3:0] aux_ldo_first_code, // first ldo voltage code
    output logic [3:0] aux_ldo_second_code, // second ldo voltage code
    output logic [3:0] aux_ldo_third_code // third ldo voltage code
);
    import lsc_pkg::*;

    // ------------------------------------------------------------
    // reset release, straps and input masking
    // ------------------------------------------------------------
    logic ready_r, ready_nxt;
    logic straps_done_r, straps_done_nxt;
    logic opt_ao_r, opt_ao_nxt;
    logic opt_lp_r, opt_lp_nxt;
    logic opt_seq_r, opt_seq_nxt;
    logic opt_vtt_r, opt_vtt_nxt;
    logic pok_seen_r, pok_seen_nxt;
    lsc_state_t state_r, state_nxt;
    logic s4_eff, s3_eff, s0_eff, trip_eff;
    logic supplies_ok;

    // supplies, straps and state decode
    always_comb
    begin
        supplies_ok = int_3v3_pg && int_5v_pg;
        straps_done_nxt = straps_done_r || supplies_ok;
        opt_ao_nxt = straps_done_r ? opt_ao_r : strap_ldo1_always_on;
        opt_lp_nxt = straps_done_r ? opt_lp_r : strap_lpddr;
        opt_seq_nxt = straps_done_r ? opt_seq_r : strap_ldo_in_seq;
        opt_vtt_nxt = straps_done_r ? opt_vtt_r : strap_vtt_off;
        // leave reset once supplies good, plus enable on gp variant
        ready_nxt = straps_done_r && supplies_ok
            && (opt_ao_r || master_enable_pin || ready_r);
        // masked views of the sleep inputs until resume reset and power ok
        s4_eff = resume_reset_n ? sleep_s4_n : 1'b0;
        s3_eff = resume_reset_n ? sleep_s3_n : 1'b0;
        trip_eff = resume_reset_n ? thermal_trip_n : 1'b1;
        s0_eff = pok_seen_r ? sleep_s0_n : 1'b1;
        pok_seen_nxt = master_enable_pin && (pok_seen_r || platform_power_ok);
        // decode; thermal trip low drops straight to g3
        if (!ready_r || !master_enable_pin || !trip_eff)
            state_nxt = PS_G3;
        else if (!s4_eff && !s3_eff)
            state_nxt = PS_S45;
        else if (!s3_eff)
            state_nxt = PS_S3;
        else if (!s0_eff)
            state_nxt = PS_S0IX;
        else
            state_nxt = PS_S0;
    end

    // control state registers
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ready_r <= 1'b0;
            straps_done_r <= 1'b0;
            opt_ao_r <= 1'b0;
            opt_lp_r <= 1'b0;
            opt_seq_r <= 1'b0;
            opt_vtt_r <= 1'b0;
            pok_seen_r <= 1'b0;
            state_r <= PS_G3;
        end
        else
        begin
            ready_r <= ready_nxt;
            straps_done_r <= straps_done_nxt;
            opt_ao_r <= opt_ao_nxt;
            opt_lp_r <= opt_lp_nxt;
            opt_seq_r <= opt_seq_nxt;
            opt_vtt_r <= opt_vtt_nxt;
            pok_seen_r <= pok_seen_nxt;
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [3:0] vcode1_r, vcode1_nxt;
    logic [3:0] vcode2_r, vcode2_nxt;
    logic [3:0] vcode3_r, vcode3_nxt;
    logic ldo1_ctl_r, ldo1_ctl_nxt;
    logic [1:0] ldo2_reg_r, ldo2_reg_nxt;
    logic ldo3_reg_r, ldo3_reg_nxt;
    logic [7:0] rdata_nxt;
    logic rvalid_nxt;
    logic wr_ok;

    // writes only once out of reset; reads answer next cycle
    always_comb
    begin
        wr_ok = reg_wr && ready_r;
        vcode1_nxt = vcode1_r;
        vcode2_nxt = vcode2_r;
        vcode3_nxt = vcode3_r;
        ldo1_ctl_nxt = ldo1_ctl_r;
        ldo2_reg_nxt = ldo2_reg_r;
        ldo3_reg_nxt = ldo3_reg_r;
        if (wr_ok)
        begin
            unique case (reg_addr)
                REG_VCODE1: vcode1_nxt = reg_wdata[VCODE_W-1:0];
                REG_VCODE2: vcode2_nxt = reg_wdata[VCODE_W-1:0];
                REG_VCODE3: vcode3_nxt = reg_wdata[VCODE_W-1:0];
                REG_LDO1_CTRL: ldo1_ctl_nxt = reg_wdata[EN_BIT];
                REG_LDO2_EN: ldo2_reg_nxt = reg_wdata[SWA_BIT:EN_BIT];
                REG_LDO3_EN: ldo3_reg_nxt = reg_wdata[EN_BIT];
                default: ;
            endcase
        end
        rvalid_nxt = reg_rd;
        rdata_nxt = 8'h00;
        if (reg_rd && ready_r)
        begin
            unique case (reg_addr)
                REG_VCODE1: rdata_nxt = {4'h0, vcode1_r};
                REG_VCODE2: rdata_nxt = {4'h0, vcode2_r};
                REG_VCODE3: rdata_nxt = {4'h0, vcode3_r};
                REG_LDO1_CTRL: rdata_nxt = {7'h00, ldo1_ctl_r};
                REG_LDO2_EN: rdata_nxt = {6'h00, ldo2_reg_r};
                REG_LDO3_EN: rdata_nxt = {7'h00, ldo3_reg_r};
                REG_STATUS: rdata_nxt = {1'b0, opt_lp_r, opt_ao_r,
                    platform_power_ok, resume_reset_n, state_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // register storage
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vcode1_r <= VCODE1_RST;
            vcode2_r <= VCODE23_RST;
            vcode3_r <= VCODE23_RST;
            ldo1_ctl_r <= 1'b0;
            ldo2_reg_r <= EN_RST;
            ldo3_reg_r <= 1'b0;
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            vcode1_r <= vcode1_nxt;
            vcode2_r <= vcode2_nxt;
            vcode3_r <= vcode3_nxt;
            ldo1_ctl_r <= ldo1_ctl_nxt;
            ldo2_reg_r <= ldo2_reg_nxt;
            ldo3_reg_r <= ldo3_reg_nxt;
            reg_rdata <= rdata_nxt;
            reg_rvalid <= rvalid_nxt;
        end
    end

    // ------------------------------------------------------------
    // rail enables and status outputs
    // ------------------------------------------------------------
    logic in_s0_nxt, on_nxt;
    logic rsm_nxt, pok_nxt, aon_nxt, vtt_nxt, swb_nxt;
    logic l1_nxt, l2_nxt, l3_nxt, swa_nxt;
    logic [3:0] code1_nxt;

    // enables from state, pins, straps and register bits
    always_comb
    begin
        on_nxt = (state_nxt != PS_G3);
        in_s0_nxt = (state_nxt == PS_S0) || (state_nxt == PS_S0IX);
        rsm_nxt = on_nxt;
        pok_nxt = in_s0_nxt;
        aon_nxt = on_nxt;
        // fused-off termination ldo is never sequenced on
        vtt_nxt = (state_nxt == PS_S0) && ddr_supply_power_good
            && !opt_vtt_r;
        swb_nxt = on_nxt && (opt_lp_r ? s4_eff : s3_eff);
        l1_nxt = opt_ao_r ? ready_nxt : (ready_r && ldo1_ctl_r);
        if (opt_seq_r)
        begin
            // sequence only rails the register leaves enabled
            l2_nxt = in_s0_nxt && ldo2_reg_r[EN_BIT];
            l3_nxt = in_s0_nxt && ldo3_reg_r;
            swa_nxt = in_s0_nxt && ldo2_reg_r[SWA_BIT];
        end
        else if (opt_ao_r)
        begin
            // pin acts as switch a enable only
            l2_nxt = ready_r && ldo2_reg_r[EN_BIT];
            l3_nxt = ready_r && ldo3_reg_r;
            swa_nxt = ready_r && (shared_ldo_switch_enable
                || ldo2_reg_r[SWA_BIT]);
        end
        else
        begin
            // pin gates all three; bits count while pin low
            l2_nxt = ready_r && (shared_ldo_switch_enable
                || ldo2_reg_r[EN_BIT]);
            l3_nxt = ready_r && (shared_ldo_switch_enable
                || ldo3_reg_r);
            swa_nxt = ready_r && (shared_ldo_switch_enable
                || ldo2_reg_r[SWA_BIT]);
        end
        // unused top code held at the highest legal one
        code1_nxt = (vcode1_r > VCODE1_MAX) ? VCODE1_MAX : vcode1_r;
    end

    // output flops
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dev_ready <= 1'b0;
            power_state <= PS_G3;
            resume_reset_n <= 1'b0;
            platform_power_ok <= 1'b0;
            aon_bucks_en <= 1'b0;
            termination_ldo_en <= 1'b0;
            combined_switch_b_en <= 1'b0;
            aux_ldo_first_en <= 1'b0;
            aux_ldo_second_en <= 1'b0;
            aux_ldo_third_en <= 1'b0;
            load_switch_a_en <= 1'b0;
            aux_ldo_first_code <= VCODE1_RST;
            aux_ldo_second_code <= VCODE23_RST;
            aux_ldo_third_code <= VCODE23_RST;
        end
        else
        begin
            dev_ready <= ready_nxt;
            power_state <= state_nxt;
            resume_reset_n <= rsm_nxt;
            platform_power_ok <= pok_nxt;
            aon_bucks_en <= aon_nxt;
            termination_ldo_en <= vtt_nxt;
            combined_switch_b_en <= swb_nxt;
            aux_ldo_first_en <= l1_nxt;
            aux_ldo_second_en <= l2_nxt;
            aux_ldo_third_en <= l3_nxt;
            load_switch_a_en <= swa_nxt;
            aux_ldo_first_code <= code1_nxt;
            aux_ldo_second_code <= vcode2_r;
            aux_ldo_third_code <= vcode3_r;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_reg_write(logic [7:0] a);
        reg_wr && ready_r && reg_addr == a;
    endsequence

    a_vtt_needs_s0: assert property (termination_ldo_en |->
        power_state == PS_S0 && !opt_vtt_r)
        else $error("termination ldo on outside s0");
    a_vtt_ddr_good: assert property (
        $rose(termination_ldo_en) |-> $past(ddr_supply_power_good))
        else $error("termination ldo on without ddr good");
    a_vcode2_write: assert property (s_reg_write(REG_VCODE2) |=>
        ##1 aux_ldo_second_code == $past(reg_wdata[3:0], 2))
        else $error("second ldo code not applied");
    a_code1_legal: assert property (aux_ldo_first_code <= VCODE1_MAX)
        else $error("first ldo code out of range");
    a_pin_gates: assert property (ready_r && !opt_seq_r && !opt_ao_r
        && shared_ldo_switch_enable |=> aux_ldo_second_en
        && aux_ldo_third_en && load_switch_a_en)
        else $error("shared pin did not enable rails");
    a_swb_follow: assert property (combined_switch_b_en |->
        power_state != PS_G3 && power_state != PS_S45)
        else $error("switch b on in s4/s5 or g3");
    a_ready_gp: assert property (!opt_ao_r && !ready_r
        && !master_enable_pin |=> !dev_ready)
        else $error("left reset without master enable");
    a_ready_ao: assert property (straps_done_r && opt_ao_r
        && supplies_ok |=> dev_ready)
        else $error("always-on variant held in reset");
    a_status_out: assert property (platform_power_ok |->
        resume_reset_n && (power_state == PS_S0
        || power_state == PS_S0IX))
        else $error("power ok outside s0 states");
    a_mask_s4: assert property (!resume_reset_n
        ##1 master_enable_pin && ready_r && thermal_trip_n
        |-> power_state != PS_S3)
        else $error("sleep input not masked before resume");
    a_aon_s45: assert property (power_state == PS_S45 |->
        aon_bucks_en && !termination_ldo_en && !platform_power_ok)
        else $error("extra rail active in s4/s5");
endmodule
`default_nettype wire

// >>> logic/lsc_pkg.sv
// Overview of operation
// - termination ldo follows s0 sleep input
// - termination ldo also needs ddr buck good
// - ldo voltage codes held at 9A 9B AE
// - first ldo codes 0 to 14, 15 unused
// - second/third ldo codes 0.70 to 1.50 V
// - second/third ldo: enable bits; shared pin too on unsequenced gp variant only
// - first ldo by control register or always-on
// - switch b follows s4 or s3 by memory
// - shared pin gates switch a per variant
// - enable bits usable while enable pin low
// - always-on variant leaves reset on supplies good
// - other variant waits for master enable
// - register-disabled rail never sequenced on
// - power state decode from five inputs
// - s4/s3 read low until resume reset rises
// - s0 read high until power ok asserted
// - thermal trip read high until resume reset
// - s4/s5 keeps always-on bucks; termination ldo, switch b and sequenced ldos off
`default_nettype none
package lsc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h98;
    localparam logic [7:0] REG_LDO1_CTRL = 8'h99;
    localparam logic [7:0] REG_VCODE1 = 8'h9A;
    localparam logic [7:0] REG_VCODE2 = 8'h9B;
    localparam logic [7:0] REG_LDO2_EN = 8'hA0;
    localparam logic [7:0] REG_LDO3_EN = 8'hA1;
    localparam logic [7:0] REG_VCODE3 = 8'hAE;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int VCODE_W = 4;
    localparam int EN_BIT = 0;
    localparam int SWA_BIT = 1;
    localparam logic [3:0] VCODE1_MAX = 4'hE;
    localparam logic [3:0] VCODE1_RST = 4'h0;
    localparam logic [3:0] VCODE23_RST = 4'h0;
    localparam logic [1:0] EN_RST = 2'h0;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_RSM_BIT = 3;
    localparam int ST_POK_BIT = 4;
    localparam int ST_AO_BIT = 5;
    localparam int ST_LP_BIT = 6;
    // ------------------------------------------------------------
    // power states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PS_G3,
        PS_S45,
        PS_S3,
        PS_S0IX,
        PS_S0
    } lsc_state_t;
endpackage
`default_nettype wire

// >>> bench/lsc_host.sv
`default_nettype none
module lsc_host (
    input wire logic sys_clk, // bench clock
    input wire lsc_pkg::lsc_state_t tgt, // state the host heads for
    input wire logic jump, // skip the ordered walk
    input wire logic trip_kill, // pull thermal trip low
    output lsc_pkg::lsc_state_t cur, // state presently signalled
    output logic master_enable_pin, // master enable
    output logic sleep_s4_n, // s4 sleep input
    output logic sleep_s3_n, // s3 sleep input
    output logic sleep_s0_n, // s0 sleep input
    output logic thermal_trip_n // thermal trip, low = trip
);
    timeunit 1ns;
    timeprecision 1ps;
    import lsc_pkg::*;
    lsc_state_t cur_r;
    lsc_state_t cur_nxt;
    logic [4:0] pins;
    // ------------------------------------------------------------
    // state walk
    // ------------------------------------------------------------
    // without jump, one ordered step per clock, s0ix only entered from s0
    always_comb
    begin
        cur_nxt = cur_r;
        if (jump)
            cur_nxt = tgt;
        else if (cur_r == PS_S0IX && tgt != PS_S0IX)
            cur_nxt = PS_S0;
        else if (cur_r == PS_S0 && tgt == PS_S0IX)
            cur_nxt = PS_S0IX;
        else if (cur_r < tgt)
            cur_nxt = (cur_r == PS_S3) ? PS_S0 : lsc_state_t'(cur_r + 3'h1);
        else if (cur_r > tgt)
            cur_nxt = (cur_r == PS_S0) ? PS_S3 : lsc_state_t'(cur_r - 3'h1);
    end
    // pins change just after the edge
    always_ff @(posedge sys_clk)
        cur_r <= cur_nxt;
    // ------------------------------------------------------------
    // pin encoding
    // ------------------------------------------------------------
    // enable, s4, s3, s0, trip for each state
    always_comb
    begin
        case (cur_r)
            PS_S45: pins = 5'h13;
            PS_S3: pins = 5'h1B;
            PS_S0IX: pins = 5'h1D;
            PS_S0: pins = 5'h1F;
            default: pins = 5'h00;
        endcase
    end
    assign cur = cur_r;
    assign {master_enable_pin, sleep_s4_n, sleep_s3_n, sleep_s0_n} = pins[4:1];
    assign thermal_trip_n = pins[0] & ~trip_kill;
endmodule
`default_nettype wire

// >>> bench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lsc_pkg::*;
    typedef struct packed {
        lsc_state_t st;
        logic [4:0] exp; // rsm, pok, aon, vtt, switch b
    } lsc_row_t;
    logic sys_clk = 1'b0;
    logic arst_n, pg3, pg5, shared_en, ddr_pg, s_ao, s_lp, s_seq, s_vo;
    logic reg_wr, reg_rd, reg_rvalid, dev_ready, jump, trip_kill;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic me, s4_n, s3_n, s0_n, trip_n;
    logic rsm_n, pok, aon, termination_ldo, ldo1, ldo2, ldo3, swa, swb;
    logic [3:0] c1, c2, c3;
    lsc_state_t power_state, tgt;
    int error_cnt = 0;
    int samples_checked = 0;
    lsc_row_t rows [6] = '{'{PS_S45, 5'h14}, '{PS_S3, 5'h15},
        '{PS_S0, 5'h1F}, '{PS_S0IX, 5'h1D}, '{PS_S3, 5'h15},
        '{PS_S0, 5'h1F}};
    logic [7:0] ca [4] = '{8'h9A, 8'h9A, 8'h9B, 8'hAE};
    logic [7:0] cd [4] = '{8'hF7, 8'h0F, 8'h3D, 8'hFF};
    logic [15:0] ce [4] = '{16'h0700, 16'h0E00, 16'h0ED0, 16'h0EDF};
    // ------------------------------------------------------------
    // design and host
    // ------------------------------------------------------------
    lsc_ctrl lsc_ctrl_inst (.sys_clk(sys_clk), .arst_n(arst_n),
        .int_3v3_pg(pg3), .int_5v_pg(pg5), .master_enable_pin(me),
        .sleep_s4_n(s4_n), .sleep_s3_n(s3_n), .sleep_s0_n(s0_n),
        .thermal_trip_n(trip_n), .shared_ldo_switch_enable(shared_en),
        .ddr_supply_power_good(ddr_pg), .strap_ldo1_always_on(s_ao),
        .strap_lpddr(s_lp), .strap_ldo_in_seq(s_seq), .strap_vtt_off(s_vo),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .dev_ready(dev_ready), .power_state(power_state),
        .resume_reset_n(rsm_n), .platform_power_ok(pok),
        .aon_bucks_en(aon), .termination_ldo_en(termination_ldo),
        .aux_ldo_first_en(ldo1), .aux_ldo_second_en(ldo2),
        .aux_ldo_third_en(ldo3), .load_switch_a_en(swa),
        .combined_switch_b_en(swb), .aux_ldo_first_code(c1),
        .aux_ldo_second_code(c2), .aux_ldo_third_code(c3));
    lsc_host lsc_host_inst (.sys_clk(sys_clk), .tgt(tgt), .jump(jump),
        .trip_kill(trip_kill), .cur(), .master_enable_pin(me),
        .sleep_s4_n(s4_n), .sleep_s3_n(s3_n), .sleep_s0_n(s0_n),
        .thermal_trip_n(trip_n));
    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic settle();
        @(posedge sys_clk) #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read answers at the take edge, checked 1 ns after it
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(16'(reg_rvalid), 16'h0001);
        chk(16'(reg_rdata), 16'(exp));
    endtask
    task automatic go(input lsc_state_t st);
        int n;
        @(posedge sys_clk);
        tgt <= st;
        settle();
        for (n = 0; n < 30 && power_state !== st; n++)
            settle();
        chk(16'(power_state), 16'(st));
    endtask
    task automatic do_reset(input logic ao, lp, seq, vo);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        {s_ao, s_lp, s_seq, s_vo} <= {ao, lp, seq, vo};
        tgt <= PS_G3;
        {jump, trip_kill, shared_en, ddr_pg} <= 4'h9;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        jump <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {arst_n, pg3, pg5, shared_en, ddr_pg, reg_wr, reg_rd} = 7'h30;
        {s_ao, s_lp, s_seq, s_vo, jump, trip_kill} = 6'h02;
        {reg_addr, reg_wdata} = 16'h0000;
        tgt = PS_G3;
        do_reset(1'b0, 1'b1, 1'b0, 1'b0);
        repeat (8) @(posedge sys_clk);
        wr(REG_VCODE1, 8'h05);
        #1;
        chk(16'(dev_ready), 16'h0000);
        foreach (rows[i])
        begin
            go(rows[i].st);
            chk({11'h0, rsm_n, pok, aon, termination_ldo, swb},
                {11'h0, rows[i].exp});
        end
        chk(16'(c1), 16'h0000);
        rd(REG_STATUS, 8'h5C);
        rd(8'hFF, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(ca[i], cd[i]);
            settle();
            chk({4'h0, c1, c2, c3}, ce[i]);
        end
        rd(REG_VCODE2, 8'h0D);
        wr(REG_LDO1_CTRL, 8'h01);
        settle();
        chk(16'(ldo1), 16'h0001);
        @(posedge sys_clk);
        shared_en <= 1'b1;
        settle();
        chk({13'h0, ldo2, ldo3, swa}, 16'h0007);
        @(posedge sys_clk);
        shared_en <= 1'b0;
        wr(REG_LDO2_EN, 8'h01);
        settle();
        chk({13'h0, ldo2, ldo3, swa}, 16'h0004);
        wr(REG_LDO2_EN, 8'h02);
        wr(REG_LDO3_EN, 8'h01);
        settle();
        chk({13'h0, ldo2, ldo3, swa}, 16'h0003);
        @(posedge sys_clk);
        ddr_pg <= 1'b0;
        settle();
        chk(16'(termination_ldo), 16'h0000);
        @(posedge sys_clk);
        trip_kill <= 1'b1;
        settle();
        chk({12'h0, power_state, rsm_n}, 16'h0000);
        // always-on variant with a host that jumps ahead
        do_reset(1'b1, 1'b0, 1'b0, 1'b0);
        repeat (4) settle();
        chk({14'h0, dev_ready, ldo1}, 16'h0003);
        @(posedge sys_clk);
        shared_en <= 1'b1;
        settle();
        chk({13'h0, ldo2, ldo3, swa}, 16'h0001);
        @(posedge sys_clk);
        tgt <= PS_S0IX;
        jump <= 1'b1;
        @(posedge sys_clk);
        jump <= 1'b0;
        for (int n = 0; n < 10 && power_state === PS_G3; n++)
            settle();
        chk(16'(power_state), 16'(PS_S45));
        settle();
        chk(16'(power_state), 16'(PS_S0));
        go(PS_S3);
        chk(16'(swb), 16'h0000);
        go(PS_S0);
        chk(16'(swb), 16'h0001);
        // sequenced rails with only the ldo3 enable bit set, termination fused off
        do_reset(1'b0, 1'b1, 1'b1, 1'b1);
        go(PS_S0);
        wr(REG_LDO3_EN, 8'h01);
        settle();
        chk({12'h0, ldo2, ldo3, swa, termination_ldo}, 16'h0004);
        give_verdict();
    end
    // hang guard
    initial
    begin
        #500000;
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
